// >>> hdl/lsmd_driver.sv
// LCD segment and backplane multiplex driver with APB register access
// ====================================================================
// Summary of operation
// - Static: backplanes 0-3 driven together, 32/24 outputs
// - Half bias: 2 or 3 slices, lines 0-2
// - Third bias: 3 or 4 slices, lines 0-3
// - Quarter bias: 8 slices, outputs drop to 28/20
// - Key-scan adds slices plus one slots per frame
// - Each output reads its own display byte per slot
// - Bit one selects, bit zero deselects the output
// - Key-scan slots take data from port registers 14/15
// - Low nibble first half, high nibble second half
// - Unused slot bits ignored, free for storage
// - Upper nibble of first four bytes reads zero
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "lsmd_regs.svh"

module lsmd_driver
   import lsmd_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter logic [15:0] SLOT_CYCLES = 16'(`LSMD_SLOT_CYCLES)
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [7:0] backplane_line,
   output logic [31:0] front_electrode_out,
   output logic key_scan_period
);

   // ====================================================================
   // Constants
   localparam int NSEG = LARGE_VARIANT ? `LSMD_SEG_LARGE : `LSMD_SEG_SMALL;
   localparam logic [11:0] DISP_END = 12'(`LSMD_DISP_BASE + `LSMD_WORD_BYTES * NSEG);

   lsmd_regs_t r;
   lsmd_regs_t n;
   logic tick;
   logic acc_wr;
   logic [4:0] widx;
   logic [4:0] kslots;

   // ====================================================================
   // Functions
   function automatic logic [3:0] lsmd_slices(input lsmd_mode_t m);
      case (m)
         LSMD_MODE_STATIC: return 4'h1;
         LSMD_MODE_HALF2: return 4'h2;
         LSMD_MODE_HALF3: return 4'h3;
         LSMD_MODE_THIRD3: return 4'h3;
         LSMD_MODE_THIRD4: return 4'h4;
         LSMD_MODE_QUARTER8: return 4'h8;
         default: return 4'h1;
      endcase
   endfunction : lsmd_slices

   function automatic logic lsmd_is_disp(input logic [11:0] a);
      return (a >= `LSMD_DISP_BASE) && (a < DISP_END) && (a[1:0] == 2'h0);
   endfunction : lsmd_is_disp

   function automatic logic lsmd_addr_ok(input logic [11:0] a);
      return (a == `LSMD_CTRL_OFS) || (a == `LSMD_STATUS_OFS) || (a == `LSMD_PORT14_OFS)
         || (a == `LSMD_PORT15_OFS) || lsmd_is_disp(a);
   endfunction : lsmd_addr_ok

   function automatic logic [4:0] lsmd_widx(input logic [11:0] a);
      logic [11:0] d;
      d = (a - `LSMD_DISP_BASE) >> 2;
      return d[4:0];
   endfunction : lsmd_widx

   // Display slot: every byte except bytes 0-3 under quarter bias gives the bit of the active backplane line
   function automatic logic [31:0] lsmd_segs(input logic [31:0][7:0] mem, input logic [3:0] slot,
                                             input lsmd_mode_t m);
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < `LSMD_MAX_SEG; i++)
      begin
         // Low-nibble bytes cannot hold eight slices, so quarter bias drops them
         if (i < NSEG && !(m == LSMD_MODE_QUARTER8 && i < `LSMD_NIBBLE_BYTES))
         begin
            v[i] = mem[i][slot[2:0]];
         end
      end
      return v;
   endfunction : lsmd_segs

   // Key-scan slot: port bits drive outputs 16-23 as plain levels
   function automatic logic [31:0] lsmd_keys(input logic [7:0] p14, input logic [7:0] p15,
                                             input logic second);
      logic [31:0] v;
      v = '0;
      for (int j = 0; j < `LSMD_KEY_BITS; j++)
      begin
         v[`LSMD_KEYSEG_LO + j] = second ? p14[`LSMD_KEY_BITS + j] : p14[j];
         v[`LSMD_KEYSEG_HI + j] = second ? p15[`LSMD_KEY_BITS + j] : p15[j];
      end
      return v;
   endfunction : lsmd_keys

   function automatic logic [7:0] lsmd_com(input lsmd_state_t s, input logic [3:0] slot,
                                           input lsmd_mode_t m);
      logic [7:0] v;
      v = '0;
      if (s == LSMD_ST_DISP)
      begin
         if (m == LSMD_MODE_STATIC)
         begin
            v = `LSMD_STATIC_COM;
         end
         else
         begin
            v[slot[2:0]] = 1'b1;
         end
      end
      return v;
   endfunction : lsmd_com

   // ====================================================================
   // Next state
   always_comb
   begin
      n = r;
      tick = (r.div == SLOT_CYCLES - 16'h0001);
      acc_wr = psel && penable && pwrite && r.pready && !r.pslverr;
      widx = lsmd_widx(paddr);
      kslots = 5'(lsmd_slices(r.mode)) + 5'h01;

      // Slot sequencer
      n.div = tick ? 16'h0000 : r.div + 16'h0001;
      case (r.state)
         LSMD_ST_IDLE:
         begin
            n.div = 16'h0000;
            n.slot = 4'h0;
            if (r.en)
            begin
               n.state = LSMD_ST_DISP;
            end
         end
         LSMD_ST_DISP:
         begin
            if (tick)
            begin
               if (r.slot + 4'h1 >= lsmd_slices(r.mode))
               begin
                  n.slot = 4'h0;
                  n.state = r.kse ? LSMD_ST_KEYS : LSMD_ST_DISP;
               end
               else
               begin
                  n.slot = r.slot + 4'h1;
               end
            end
         end
         LSMD_ST_KEYS:
         begin
            if (tick)
            begin
               if (5'(r.slot) + 5'h01 >= kslots)
               begin
                  n.slot = 4'h0;
                  n.state = LSMD_ST_DISP;
               end
               else
               begin
                  n.slot = r.slot + 4'h1;
               end
            end
         end
         default:
         begin
            n.state = LSMD_ST_IDLE;
         end
      endcase
      if (!r.en)
      begin
         n.state = LSMD_ST_IDLE;
      end

      // APB: answer prepared in setup, write taken at the access edge
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel && !penable)
      begin
         n.pready = 1'b1;
         n.pslverr = !lsmd_addr_ok(paddr);
         n.prdata = '0;
         if (paddr == `LSMD_CTRL_OFS)
         begin
            n.prdata[`LSMD_CTRL_MODE_MSB:`LSMD_CTRL_MODE_LSB] = r.mode;
            n.prdata[`LSMD_CTRL_KSE_BIT] = r.kse;
            n.prdata[`LSMD_CTRL_EN_BIT] = r.en;
         end
         else if (paddr == `LSMD_STATUS_OFS)
         begin
            n.prdata[7:0] = {r.state, r.ks, r.slot};
         end
         else if (paddr == `LSMD_PORT14_OFS)
         begin
            n.prdata[7:0] = r.port14;
         end
         else if (paddr == `LSMD_PORT15_OFS)
         begin
            n.prdata[7:0] = r.port15;
         end
         else if (lsmd_is_disp(paddr))
         begin
            n.prdata[7:0] = r.disp[widx];
         end
      end
      if (acc_wr)
      begin
         if (paddr == `LSMD_CTRL_OFS)
         begin
            n.mode = lsmd_mode_t'(pwdata[`LSMD_CTRL_MODE_MSB:`LSMD_CTRL_MODE_LSB]);
            n.kse = pwdata[`LSMD_CTRL_KSE_BIT];
            n.en = pwdata[`LSMD_CTRL_EN_BIT];
            // Restart the frame so a slot never overruns the new slice count
            n.slot = 4'h0;
            n.div = 16'h0000;
            n.state = pwdata[`LSMD_CTRL_EN_BIT] ? LSMD_ST_DISP : LSMD_ST_IDLE;
         end
         else if (paddr == `LSMD_PORT14_OFS)
         begin
            n.port14 = pwdata[7:0];
         end
         else if (paddr == `LSMD_PORT15_OFS)
         begin
            n.port15 = pwdata[7:0];
         end
         else if (lsmd_is_disp(paddr))
         begin
            // Upper nibble of the first bytes does not exist
            n.disp[widx] = (widx < 5'(`LSMD_NIBBLE_BYTES)) ? (pwdata[7:0] & `LSMD_NIBBLE_MASK)
                                                            : pwdata[7:0];
         end
      end

      // Drive levels registered from the next slot state
      n.ks = (n.state == LSMD_ST_KEYS);
      n.com = lsmd_com(n.state, n.slot, n.mode);
      if (n.state == LSMD_ST_KEYS)
      begin
         n.seg = lsmd_keys(n.port14, n.port15,
                           ({1'b0, n.slot} << 1) >= (5'(lsmd_slices(n.mode)) + 5'h01));
      end
      else if (n.state == LSMD_ST_DISP)
      begin
         n.seg = lsmd_segs(n.disp, n.slot, n.mode);
      end
      else
      begin
         n.seg = '0;
      end
   end

   // ====================================================================
   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '{state: LSMD_ST_IDLE, mode: LSMD_MODE_STATIC, kse: 1'b0, en: 1'b0,
                port14: `LSMD_PORT_RST, port15: `LSMD_PORT_RST, disp: '0, slot: 4'h0,
                div: 16'h0000, com: 8'h00, seg: 32'h0000_0000, ks: 1'b0, pready: 1'b0,
                pslverr: 1'b0, prdata: 32'h0000_0000};
      end
      else
      begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign backplane_line = r.com;
   assign front_electrode_out = r.seg;
   assign key_scan_period = r.ks;

   // ====================================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_static_backplane: assert property ((r.state == LSMD_ST_DISP && r.mode == LSMD_MODE_STATIC)
      |-> r.com == `LSMD_STATIC_COM)
      else $error("static mode backplane pattern wrong");

   a_half_lines: assert property ((r.state == LSMD_ST_DISP && r.mode == LSMD_MODE_HALF2)
      |-> r.com[7:2] == 6'h00 && $onehot(r.com))
      else $error("half bias drives a line above 1");

   a_third_lines: assert property ((r.state == LSMD_ST_DISP && r.mode == LSMD_MODE_THIRD4)
      |-> r.com[7:4] == 4'h0 && r.com[r.slot[2:0]])
      else $error("third bias backplane wrong");

   a_quarter_edge: assert property ((r.state == LSMD_ST_DISP && r.mode == LSMD_MODE_QUARTER8)
      |-> r.seg[3:0] == 4'h0 && r.com == (8'h01 << r.slot[2:0]))
      else $error("quarter bias uses a dropped output");

   a_keys_length: assert property ((r.state == LSMD_ST_KEYS)
      |-> 5'(r.slot) <= 5'(lsmd_slices(r.mode)))
      else $error("key-scan period too long");

   a_seg_source: assert property ((r.state == LSMD_ST_DISP && r.mode != LSMD_MODE_QUARTER8)
      |-> r.seg[5] == r.disp[5][r.slot[2:0]] && r.seg[0] == r.disp[0][r.slot[2:0]])
      else $error("front output does not follow its display bit");

   a_keys_port: assert property ((r.state == LSMD_ST_KEYS && r.slot == 4'h0)
      |-> r.seg[16] == r.port14[0] && r.seg[20] == r.port15[0] && r.seg[15:0] == 16'h0000)
      else $error("key-scan output not from port registers");

   a_nibble_zero: assert property (r.disp[0][7:4] == 4'h0 && r.disp[3][7:4] == 4'h0)
      else $error("hardwired nibble not zero");

   a_slot_step: assert property ((r.state == LSMD_ST_DISP && tick && !acc_wr && r.en
      && r.slot + 4'h1 < lsmd_slices(r.mode)) |=> r.slot == $past(r.slot) + 4'h1)
      else $error("slot did not advance");

   a_apb_answer: assert property ((psel && !penable) |=> r.pready ##1 !r.pready)
      else $error("APB answer timing wrong");

   c_static_frame: cover property (r.state == LSMD_ST_DISP && r.mode == LSMD_MODE_STATIC);
   c_quarter_last: cover property (r.state == LSMD_ST_DISP && r.mode == LSMD_MODE_QUARTER8
      && r.slot == 4'h7);
   c_keys_second: cover property (r.state == LSMD_ST_KEYS && r.slot == 4'h2);
   c_disp_write: cover property (acc_wr && lsmd_is_disp(paddr));

endmodule : lsmd_driver
`default_nettype wire

// >>> hdl/lsmd_pkg.sv
// Types shared by the LCD segment driver
`default_nettype none
package lsmd_pkg;

   typedef enum logic [2:0]
   {
      LSMD_MODE_STATIC = 3'h0,
      LSMD_MODE_HALF2 = 3'h1,
      LSMD_MODE_HALF3 = 3'h2,
      LSMD_MODE_THIRD3 = 3'h3,
      LSMD_MODE_THIRD4 = 3'h4,
      LSMD_MODE_QUARTER8 = 3'h5
   } lsmd_mode_t;

   typedef enum logic [2:0]
   {
      LSMD_ST_IDLE = 3'h1,
      LSMD_ST_DISP = 3'h2,
      LSMD_ST_KEYS = 3'h4
   } lsmd_state_t;

   typedef struct packed
   {
      lsmd_state_t state;
      lsmd_mode_t mode;
      logic kse;
      logic en;
      logic [7:0] port14;
      logic [7:0] port15;
      logic [31:0][7:0] disp;
      logic [3:0] slot;
      logic [15:0] div;
      logic [7:0] com;
      logic [31:0] seg;
      logic ks;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } lsmd_regs_t;

endpackage : lsmd_pkg
`default_nettype wire

// >>> hdl/lsmd_regs.svh
// Register offsets, field positions, reset values and timing counts of the LCD segment driver
`ifndef LSMD_REGS_SVH
`define LSMD_REGS_SVH

// ====================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define LSMD_CTRL_OFS 12'h000
`define LSMD_STATUS_OFS 12'h004
`define LSMD_PORT14_OFS 12'h008
`define LSMD_PORT15_OFS 12'h00c
`define LSMD_DISP_BASE 12'h100
`define LSMD_WORD_BYTES 12'h004

// ====================================================================
// Control register fields
`define LSMD_CTRL_MODE_LSB 0
`define LSMD_CTRL_MODE_MSB 2
`define LSMD_CTRL_KSE_BIT 4
`define LSMD_CTRL_EN_BIT 8

// ====================================================================
// Display memory layout
`define LSMD_MAX_SEG 32
`define LSMD_SEG_LARGE 32
`define LSMD_SEG_SMALL 24
`define LSMD_NIBBLE_BYTES 4
`define LSMD_NIBBLE_MASK 8'h0f
`define LSMD_KEYSEG_LO 16
`define LSMD_KEYSEG_HI 20
`define LSMD_KEY_BITS 4

// ====================================================================
// Reset values and timing
`define LSMD_PORT_RST 8'h00
`define LSMD_STATIC_COM 8'h0f
`define LSMD_SLOT_CYCLES 16

`endif

// >>> verification/lsmd_panel.sv
// Glass panel model latching the segment pattern seen on each backplane line
`timescale 1ns/10ps
`default_nettype none
// ====================================================================
// Panel
module lsmd_panel
(
   input wire logic pclk,
   input wire logic [7:0] backplane_line,
   input wire logic [31:0] front_electrode_out,
   input wire logic key_scan_period,
   output logic [7:0][31:0] pix
);
   // Key slots feed switches, not pixels, so they never reach the glass
   always @(posedge pclk)
   begin
      for (int k = 0; k < 8; k++)
      begin
         if (backplane_line[k] === 1'b1 && key_scan_period === 1'b0)
         begin
            pix[k] <= front_electrode_out;
         end
      end
   end
endmodule : lsmd_panel
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking testbench of the LCD segment multiplex driver
`timescale 1ns/10ps
`default_nettype none
`include "lsmd_regs.svh"
// ====================================================================
// Bench
module tb_top;
   localparam int SC = 2;
   localparam int NSEG = 24;
   int slices [6] = '{1, 2, 3, 3, 4, 8};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, key_scan_period, err, chk;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, front_electrode_out, rd;
   logic [7:0] backplane_line, kv;
   logic [7:0][31:0] pix;
   int mismatches, n_compared, cycles, mode, dc, kc, s, port14, port15;
   int mem [NSEG];

   // Small variant, short slots to keep frames brief
   lsmd_driver #(.LARGE_VARIANT(1'b0), .SLOT_CYCLES(16'(SC))) i_dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .backplane_line(backplane_line), .front_electrode_out(front_electrode_out),
      .key_scan_period(key_scan_period)
   );

   lsmd_panel i_panel
   (
      .pclk(pclk), .backplane_line(backplane_line), .front_electrode_out(front_electrode_out),
      .key_scan_period(key_scan_period), .pix(pix)
   );

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // ====================================================================
   // Model and checks
   function automatic logic [31:0] exp_seg(input int k);
      exp_seg = '0;
      for (int i = 0; i < NSEG; i++)
         exp_seg[i] = (mode == 5 && i < 4) ? 1'b0 : mem[i][k];
   endfunction : exp_seg

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] v);
      n_compared++;
      if (v !== e)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, e, v);
      end
   endtask : check

   task automatic final_report;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      check("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic fill;
      int d;
      for (int i = 0; i < NSEG; i++)
      begin
         d = $urandom % 256;
         mem[i] = (i < 4) ? (d & 15) : d;
         apb(1'b1, `LSMD_DISP_BASE + 12'(4 * i), d);
         apb(1'b0, `LSMD_DISP_BASE + 12'(4 * i), 0);
         check("display byte", mem[i], rd);
      end
   endtask : fill

   // Frame follower: slot index comes from the counts, never from the outputs
   always @(posedge pclk)
   begin
      if (chk)
      begin
         s = slices[mode];
         if (key_scan_period === 1'b1)
         begin
            if (dc != 0)
               check("display cycles", s * SC, dc);
            dc = 0;
            kv = (2 * (kc / SC) < s + 1) ? {port15[3:0], port14[3:0]} : {port15[7:4], port14[7:4]};
            check("key segments", {8'h0, kv, 16'h0}, front_electrode_out);
            check("key lines", 0, backplane_line);
            kc++;
         end
         else
         begin
            if (kc != 0)
               check("key cycles", (s + 1) * SC, kc);
            kc = 0;
            check("lines", mode == 0 ? 32'h0f : 32'h1 << ((dc / SC) % s), backplane_line);
            check("segments", exp_seg((dc / SC) % s), front_electrode_out);
            dc++;
         end
      end
      cycles++;
      if (cycles > 20000)
      begin
         mismatches++;
         final_report();
      end
   end

   // ====================================================================
   // Sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, presetn, chk} = '0;
      {cycles, mismatches, n_compared, mode, dc, kc} = '0;
      void'($urandom(32'ha1201cd9));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `LSMD_CTRL_OFS, 0);
      check("control reset", 0, rd);
      apb(1'b0, `LSMD_PORT14_OFS, 0);
      check("port reset", 0, rd);
      apb(1'b1, 12'h050, 32'h5a);
      check("unmapped write", 1, err);
      apb(1'b0, 12'h050, 0);
      check("unmapped read", 32'h1, {31'h0, err} | rd);
      port14 = $urandom % 256;
      port15 = $urandom % 256;
      apb(1'b1, `LSMD_PORT14_OFS, port14);
      apb(1'b1, `LSMD_PORT15_OFS, port15);
      apb(1'b0, `LSMD_PORT15_OFS, 0);
      check("port readback", port15, rd);
      for (mode = 0; mode < 6; mode++)
         for (int kse = 0; kse < 2; kse++)
         begin
            fill();
            dc = 0;
            kc = 0;
            apb(1'b1, `LSMD_CTRL_OFS, 32'h100 | (kse << 4) | mode);
            chk <= 1'b1;
            repeat (3 * (2 * slices[mode] + 1) * SC) @(posedge pclk);
            chk <= 1'b0;
            // Let the follower finish this mode before the model state moves on
            @(posedge pclk);
            for (int k = 0; k < slices[mode]; k++)
               check("panel pattern", exp_seg(k), pix[k]);
         end
      apb(1'b1, `LSMD_CTRL_OFS, 0);
      repeat (2) @(posedge pclk);
      check("idle segments", 0, front_electrode_out);
      check("idle lines", 0, backplane_line);
      final_report();
   end
endmodule : tb_top
`default_nettype wire
